// file: rtl/brsd_rest_detector.sv
`timescale 1ns/1ps
`include "brsd_params.svh"
// Behaviour
// R1: Discharge flag high only while averaged current below minus discharge threshold.
// R2: Charge threshold marks charge current; independent, never touches discharge flag.
// R3: Rest from discharge after in-band current for discharge rest time.
// R4: Rest from charge after in-band current for charge rest time.
// R5: Rest timer starts on entering band; leaving band cancels it.
// R6: After thirty minutes of rest, test voltage slope against configurable limit.
// R7: Slope criterion met during rest captures open-circuit voltage reading.
// R8: Block capacity update after charge if OCV below bound plus shift.
// R9: New OCV resets scaling factor, subject to temperature threshold.
// R10: Peak-current capability computed from pulse current and duration.
// R11: Interrupt when peak capability moved by step since last interrupt.
// R12: Zero capacity after voltage below terminate for qualification time.
// R13: Smooth charge percentage during rest for smoothing time, minimum one.
// R14: Wait configured delay after activity begins before ambient prediction.
// R15: Software keeps rest threshold small and below both detection thresholds.
// R16: Second timers count a one-second tick; excursions restart them.
module brsd_rest_detector
  import brsd_pkg::*;
#(
  parameter int CLK_HZ = `BRSD_CLK_HZ
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Avalon-MM slave
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Measurements
  input wire logic signed [15:0] averagedCurrent,
  input wire logic [15:0] cellVoltage,
  input wire logic [15:0] terminateVoltage,
  input wire logic signed [15:0] cellTemp,
  input wire logic [15:0] voltageSlope,
  // Results
  output logic dischargeFlag,
  output logic chargeFlag,
  output logic restFlag,
  output logic ocvCapture,
  output logic scaleReset,
  output logic [15:0] ocvValue,
  output logic forceZeroCapacity,
  output logic smoothActive,
  output logic predictEnable,
  output logic [15:0] peakCurrent,
  output logic interruptOutputPin
);
  // ==========================================
  // Timing constants
  localparam int TICK_CYC = CLK_HZ * `BRSD_TICK_S;
  localparam int SETTLE_S = `BRSD_REST_SETTLE_MIN * 60;

  // ==========================================
  // Configuration registers
  // Detection thresholds and rest delays
  logic [15:0] dsgDet_r;
  logic [15:0] chgDet_r;
  logic [15:0] restCur_r;
  logic [15:0] dsgRest_r;
  logic [15:0] chgRest_r;

  // Voltage, temperature and peak settings
  logic [15:0] hysShift_r;
  logic [15:0] sclTemp_r;
  logic [15:0] pulseCur_r;
  logic [15:0] pulseDur_r;
  logic [15:0] irqStep_r;

  // Timer lengths, flat voltage bound and slope limit
  logic [15:0] smooth_r;
  logic [15:0] predict_r;
  logic [15:0] qualT_r;
  logic [15:0] flatUb_r;
  logic [15:0] slopeLim_r;

  // Interrupt state and bus phase
  logic [3:0] irqStat_r;
  logic [3:0] irqMask_r;
  logic [3:0] irqSet;
  logic busy_r; // Answering cycle of a request

  // Bus decode; writes land once, on the answering cycle
  wire logic wrEn = avsWrite && clkEn && busy_r;
  wire logic [15:0] wd16 = avsWriteData[15:0];

  wire logic wrDsg = wrEn && avsAddress == `BRSD_IDX_DSG_DET;
  wire logic wrChg = wrEn && avsAddress == `BRSD_IDX_CHG_DET;
  wire logic wrRc = wrEn && avsAddress == `BRSD_IDX_REST_CUR;
  wire logic wrDr = wrEn && avsAddress == `BRSD_IDX_DSG_REST;
  wire logic wrCr = wrEn && avsAddress == `BRSD_IDX_CHG_REST;
  wire logic wrHs = wrEn && avsAddress == `BRSD_IDX_HYS_SHIFT;
  wire logic wrSt = wrEn && avsAddress == `BRSD_IDX_SCL_TEMP;
  wire logic wrPc = wrEn && avsAddress == `BRSD_IDX_PULSE_CUR;
  wire logic wrPd = wrEn && avsAddress == `BRSD_IDX_PULSE_DUR;
  wire logic wrIs = wrEn && avsAddress == `BRSD_IDX_IRQ_STEP;
  wire logic wrSm = wrEn && avsAddress == `BRSD_IDX_SMOOTH;
  wire logic wrPr = wrEn && avsAddress == `BRSD_IDX_PREDICT;
  wire logic wrQt = wrEn && avsAddress == `BRSD_IDX_QUAL_T;
  wire logic wrFu = wrEn && avsAddress == `BRSD_IDX_FLAT_UB;
  wire logic wrSl = wrEn && avsAddress == `BRSD_IDX_SLOPE_LIM;
  wire logic wrIst = wrEn && avsAddress == `BRSD_IDX_IRQ_STAT;
  wire logic wrImk = wrEn && avsAddress == `BRSD_IDX_IRQ_MASK;

  // Register writes, low 16 bits honour byte enables
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [3:0] be);
    merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Power-on settings
      dsgDet_r <= `BRSD_RST_DSG_DET;
      chgDet_r <= `BRSD_RST_CHG_DET;
      restCur_r <= `BRSD_RST_REST_CUR;
      dsgRest_r <= `BRSD_RST_DSG_REST;
      chgRest_r <= `BRSD_RST_CHG_REST;
      hysShift_r <= `BRSD_RST_HYS_SHIFT;
      sclTemp_r <= `BRSD_RST_SCL_TEMP;
      pulseCur_r <= `BRSD_RST_PULSE_CUR;
      pulseDur_r <= `BRSD_RST_PULSE_DUR;
      irqStep_r <= `BRSD_RST_IRQ_STEP;
      smooth_r <= `BRSD_RST_SMOOTH;
      predict_r <= `BRSD_RST_PREDICT;
      qualT_r <= `BRSD_RST_QUAL_T;
      flatUb_r <= `BRSD_RST_FLAT_UB;
      slopeLim_r <= `BRSD_RST_SLOPE_LIM;
      irqMask_r <= 4'h0;
    end else begin
      if (wrDsg) dsgDet_r <= merge(dsgDet_r, wd16, avsByteEnable);
      if (wrChg) chgDet_r <= merge(chgDet_r, wd16, avsByteEnable);
      if (wrRc) restCur_r <= merge(restCur_r, wd16, avsByteEnable);
      if (wrDr) dsgRest_r <= merge(dsgRest_r, wd16, avsByteEnable);
      // Byte-wide settings take lane 0 only
      if (wrCr && avsByteEnable[0]) chgRest_r <= {8'h00, wd16[7:0]};
      if (wrHs) hysShift_r <= merge(hysShift_r, wd16, avsByteEnable);
      if (wrSt && avsByteEnable[0]) sclTemp_r <= {8'h00, wd16[7:0]};
      if (wrPc) pulseCur_r <= merge(pulseCur_r, wd16, avsByteEnable);
      if (wrPd && avsByteEnable[0]) pulseDur_r <= {8'h00, wd16[7:0]};
      if (wrIs) irqStep_r <= merge(irqStep_r, wd16, avsByteEnable);
      if (wrSm) smooth_r <= merge(smooth_r, wd16, avsByteEnable);
      if (wrPr) predict_r <= merge(predict_r, wd16, avsByteEnable);
      if (wrQt && avsByteEnable[0]) qualT_r <= {8'h00, wd16[7:0]};
      if (wrFu) flatUb_r <= merge(flatUb_r, wd16, avsByteEnable);
      if (wrSl) slopeLim_r <= merge(slopeLim_r, wd16, avsByteEnable);
      if (wrImk && avsByteEnable[0]) irqMask_r <= wd16[3:0];
    end
  end

  // ==========================================
  // One-second tick
  logic [31:0] tickCnt_r;
  logic tick_r;
  // Divider; tick is a one-cycle strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (clkEn) begin
      tick_r <= (tickCnt_r == 32'(TICK_CYC - 1)); // R16
      tickCnt_r <= (tickCnt_r == 32'(TICK_CYC - 1)) ? 32'h0
                   : tickCnt_r + 32'h1;
    end
  end

  // ==========================================
  // Current classification
  // Widened to 17 bits so a negated threshold cannot wrap
  wire logic signed [16:0] curS = 17'(averagedCurrent);
  wire logic isDsg = curS < -$signed({1'b0, dsgDet_r}); // R1
  wire logic isChg = curS > $signed({1'b0, chgDet_r}); // R2
  wire logic belowRest = curS < -$signed({1'b0, restCur_r});
  wire logic aboveRest = curS > $signed({1'b0, restCur_r});
  wire logic inBand = !belowRest && !aboveRest;

  // ==========================================
  // Mode machine and rest timer
  brsd_mode_t mode_r, mode_nxt;
  logic lastDir_r; // 1 when last out-of-band excursion was charge
  logic armed_r;
  logic [15:0] restCnt_r;
  logic [15:0] settleCnt_r;
  wire logic [15:0] restLimit = lastDir_r ? chgRest_r : dsgRest_r;
  // Rest needs an excursion, then a full in-band run
  wire logic restDone = armed_r && inBand && restCnt_r >= restLimit;
  wire logic settled = settleCnt_r >= 16'(SETTLE_S);

  // Slope only tested once settled
  wire logic slopeOk = settled && voltageSlope < slopeLim_r; // R6
  // Hysteresis guard only after a charge excursion
  wire logic qmaxBlock = lastDir_r &&
      ({1'b0, cellVoltage} < {1'b0, flatUb_r} + {1'b0, hysShift_r}); // R8
  wire logic tempOk = cellTemp >= $signed(sclTemp_r); // R9

  // Next mode
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      BRSD_ACTIVE: if (restDone) mode_nxt = BRSD_REST; // R3 R4
      BRSD_REST: begin
        if (!inBand) mode_nxt = BRSD_ACTIVE;
        else if (slopeOk) mode_nxt = BRSD_OCV_DONE; // R7
      end
      BRSD_OCV_DONE: if (!inBand) mode_nxt = BRSD_ACTIVE;
      default: mode_nxt = BRSD_ACTIVE;
    endcase
  end

  // Rest timers and OCV capture
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= BRSD_ACTIVE;
      lastDir_r <= 1'b0;
      armed_r <= 1'b0;
      restCnt_r <= 16'h0;
      settleCnt_r <= 16'h0;
      ocvCapture <= 1'b0;
      scaleReset <= 1'b0;
      ocvValue <= 16'h0;
    end else if (clkEn) begin
      mode_r <= mode_nxt;
      ocvCapture <= 1'b0;
      scaleReset <= 1'b0;
      // Any excursion re-arms and restarts the timer
      if (!inBand) begin
        armed_r <= 1'b1;
        lastDir_r <= aboveRest;
        restCnt_r <= 16'h0; // R5 R16
      end else if (tick_r && mode_r == BRSD_ACTIVE && armed_r &&
                   restCnt_r != 16'hffff) begin
        restCnt_r <= restCnt_r + 16'h1; // R5
      end
      // Settle count runs in rest, saturating
      if (mode_r == BRSD_ACTIVE) settleCnt_r <= 16'h0;
      else if (tick_r && !settled) settleCnt_r <= settleCnt_r + 16'h1;
      if (mode_r == BRSD_REST && mode_nxt == BRSD_OCV_DONE) begin
        ocvCapture <= 1'b1; // R7
        ocvValue <= cellVoltage;
        scaleReset <= tempOk; // R9
      end
      if (mode_nxt == BRSD_REST) armed_r <= 1'b0;
    end
  end

  // ==========================================
  // Peak current and step interrupt
  logic [15:0] irqBase_r;
  // 16 by 8 product always fits 24 bits
  wire logic [23:0] peakProd = pulseCur_r * pulseDur_r[7:0];
  // Scale by the default 10 s pulse reference
  wire logic [15:0] peakNxt = 16'(peakProd / 24'd10); // R10
  // Distance from the figure at the last interrupt
  wire logic [15:0] peakDiff = peakCurrent > irqBase_r
      ? peakCurrent - irqBase_r : irqBase_r - peakCurrent;
  wire logic peakStep = peakDiff >= irqStep_r && irqStep_r != 16'h0; // R11

  // ==========================================
  // Terminate, smoothing and prediction timers
  logic [15:0] termCnt_r;
  logic [15:0] smoothCnt_r;
  logic [15:0] predCnt_r;
  wire logic belowTerm = cellVoltage < terminateVoltage;
  wire logic termQual = belowTerm && termCnt_r >= qualT_r; // R12
  // Zero smoothing time acts as one second
  wire logic [15:0] smoothLim = (smooth_r == 16'h0) ? 16'h1 : smooth_r;
  wire logic resting = mode_r != BRSD_ACTIVE;
  // Prediction delay runs while current flows
  wire logic active = isDsg || isChg;

  // Flags and second timers, frozen with clkEn
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      termCnt_r <= 16'h0;
      smoothCnt_r <= 16'h0;
      predCnt_r <= 16'h0;
      forceZeroCapacity <= 1'b0;
      smoothActive <= 1'b0;
      predictEnable <= 1'b0;
      peakCurrent <= 16'h0;
      irqBase_r <= 16'h0;
      dischargeFlag <= 1'b0;
      chargeFlag <= 1'b0;
      restFlag <= 1'b0;
    end else if (clkEn) begin
      dischargeFlag <= isDsg; // R1
      chargeFlag <= isChg; // R2
      restFlag <= resting;
      peakCurrent <= peakNxt;
      if (peakStep) irqBase_r <= peakCurrent; // R11
      if (!belowTerm) termCnt_r <= 16'h0; // R16
      else if (tick_r && !termQual) termCnt_r <= termCnt_r + 16'h1;
      forceZeroCapacity <= termQual; // R12
      if (!resting) smoothCnt_r <= 16'h0;
      else if (tick_r && smoothCnt_r < smoothLim)
        smoothCnt_r <= smoothCnt_r + 16'h1;
      smoothActive <= resting && smoothCnt_r < smoothLim; // R13
      if (!active) predCnt_r <= 16'h0;
      else if (tick_r && predCnt_r < predict_r)
        predCnt_r <= predCnt_r + 16'h1;
      predictEnable <= active && predCnt_r >= predict_r; // R14
    end
  end

  // ==========================================
  // Interrupt status, set wins over clear
  assign irqSet = {mode_r == BRSD_ACTIVE && mode_nxt == BRSD_REST,
                   termQual && !forceZeroCapacity,
                   mode_r == BRSD_REST && mode_nxt == BRSD_OCV_DONE,
                   peakStep};
  // Write-one-to-clear, lane 0
  wire logic [3:0] irqClr = (wrIst && avsByteEnable[0]) ? wd16[3:0] : 4'h0;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_r <= 4'h0;
      interruptOutputPin <= 1'b0;
    end else if (clkEn) begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      interruptOutputPin <= |(irqStat_r & irqMask_r); // R11
    end
  end

  // ==========================================
  // Read mux
  // Live flags for software
  wire logic [15:0] statusWord = {7'h00, scaleReset, predictEnable,
      smoothActive, forceZeroCapacity, !qmaxBlock, slopeOk, resting,
      chargeFlag, dischargeFlag};
  logic [15:0] rdMux;
  // Unmapped indices read zero
  always_comb begin
    case (avsAddress)
      `BRSD_IDX_DSG_DET: rdMux = dsgDet_r;
      `BRSD_IDX_CHG_DET: rdMux = chgDet_r;
      `BRSD_IDX_REST_CUR: rdMux = restCur_r;
      `BRSD_IDX_DSG_REST: rdMux = dsgRest_r;
      `BRSD_IDX_CHG_REST: rdMux = chgRest_r;
      `BRSD_IDX_HYS_SHIFT: rdMux = hysShift_r;
      `BRSD_IDX_SCL_TEMP: rdMux = sclTemp_r;
      `BRSD_IDX_PULSE_CUR: rdMux = pulseCur_r;
      `BRSD_IDX_PULSE_DUR: rdMux = pulseDur_r;
      `BRSD_IDX_IRQ_STEP: rdMux = irqStep_r;
      `BRSD_IDX_SMOOTH: rdMux = smooth_r;
      `BRSD_IDX_PREDICT: rdMux = predict_r;
      `BRSD_IDX_QUAL_T: rdMux = qualT_r;
      `BRSD_IDX_FLAT_UB: rdMux = flatUb_r;
      `BRSD_IDX_SLOPE_LIM: rdMux = slopeLim_r;
      `BRSD_IDX_STATUS: rdMux = statusWord;
      `BRSD_IDX_IRQ_STAT: rdMux = {12'h000, irqStat_r};
      `BRSD_IDX_IRQ_MASK: rdMux = {12'h000, irqMask_r};
      `BRSD_IDX_PEAK: rdMux = peakCurrent;
      default: rdMux = 16'h0000;
    endcase
  end

  // One wait cycle per access, data registered
  // Handshake keeps running while clkEn is low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0;
    end else begin
      avsReadData <= {16'h0000, rdMux};
      busy_r <= (avsRead || avsWrite) && !busy_r;
      avsWaitRequest <= !((avsRead || avsWrite) && !busy_r);
    end
  end
endmodule

// file: rtl/brsd_params.svh
`ifndef BRSD_PARAMS_SVH
`define BRSD_PARAMS_SVH
// ==========================================
// Register addresses (compared directly with avsAddress)
`define BRSD_IDX_DSG_DET 8'h00
`define BRSD_IDX_CHG_DET 8'h02
`define BRSD_IDX_REST_CUR 8'h04
`define BRSD_IDX_DSG_REST 8'h06
`define BRSD_IDX_CHG_REST 8'h08
`define BRSD_IDX_HYS_SHIFT 8'h6a
`define BRSD_IDX_SCL_TEMP 8'h6c
`define BRSD_IDX_PULSE_CUR 8'h6d
`define BRSD_IDX_PULSE_DUR 8'h6f
`define BRSD_IDX_IRQ_STEP 8'h70
`define BRSD_IDX_SMOOTH 8'h72
`define BRSD_IDX_PREDICT 8'h74
`define BRSD_IDX_QUAL_T 8'h76
`define BRSD_IDX_FLAT_UB 8'h80
`define BRSD_IDX_SLOPE_LIM 8'h81
`define BRSD_IDX_STATUS 8'h82
`define BRSD_IDX_IRQ_STAT 8'h83
`define BRSD_IDX_IRQ_MASK 8'h84
`define BRSD_IDX_PEAK 8'h85
// ==========================================
// Reset values
`define BRSD_RST_DSG_DET 16'h003c
`define BRSD_RST_CHG_DET 16'h004b
`define BRSD_RST_REST_CUR 16'h0028
`define BRSD_RST_DSG_REST 16'h003c
`define BRSD_RST_CHG_REST 16'h003c
`define BRSD_RST_HYS_SHIFT 16'h0028
`define BRSD_RST_SCL_TEMP 16'h000f
`define BRSD_RST_PULSE_CUR 16'h2134
`define BRSD_RST_PULSE_DUR 16'h000a
`define BRSD_RST_IRQ_STEP 16'h01f4
`define BRSD_RST_SMOOTH 16'h03e8
`define BRSD_RST_PREDICT 16'h07d0
`define BRSD_RST_QUAL_T 16'h0002
`define BRSD_RST_FLAT_UB 16'h0ed8
`define BRSD_RST_SLOPE_LIM 16'h0004
// ==========================================
// Status and interrupt bit positions
`define BRSD_BIT_DSG 0
`define BRSD_BIT_CHG 1
`define BRSD_BIT_REST 2
`define BRSD_BIT_SLOPE 3
`define BRSD_BIT_QMAX_OK 4
`define BRSD_BIT_ZERO 5
`define BRSD_BIT_SMOOTH 6
`define BRSD_BIT_PREDICT 7
`define BRSD_BIT_SCL_RST 8
`define BRSD_IRQ_PEAK 0
`define BRSD_IRQ_OCV 1
`define BRSD_IRQ_ZERO 2
`define BRSD_IRQ_REST 3
// ==========================================
// Timing
`define BRSD_CLK_HZ 10000000
`define BRSD_TICK_S 1
`define BRSD_REST_SETTLE_MIN 30
`endif

// file: rtl/brsd_pkg.sv
package brsd_pkg;
  // ==========================================
  // Gauge operating modes
  typedef enum logic [2:0] {
    BRSD_ACTIVE = 3'b001,
    BRSD_REST = 3'b010,
    BRSD_OCV_DONE = 3'b100
  } brsd_mode_t;
endpackage

// file: bench/brsd_rest_properties.sv
`timescale 1ns/1ps
// ==========================================
// Port-level checker for the rest detector
module brsd_rest_checker
  import brsd_pkg::*;
#(
  parameter int CLK_HZ = 10,
  parameter int REST_BAND = 40
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Bus
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  // Measurements
  input wire logic signed [15:0] averagedCurrent,
  input wire logic [15:0] cellVoltage,
  input wire logic [15:0] terminateVoltage,
  // Results
  input wire logic dischargeFlag,
  input wire logic chargeFlag,
  input wire logic restFlag,
  input wire logic ocvCapture,
  input wire logic scaleReset,
  input wire logic forceZeroCapacity,
  input wire logic smoothActive,
  input wire logic interruptOutputPin
);
  logic inBand;
  logic isLow;
  logic [15:0] inBandCnt_r;
  logic [15:0] lowCnt_r;

  // Qualifying conditions seen at the pins
  assign inBand = (averagedCurrent <= REST_BAND) &&
                  (averagedCurrent >= -REST_BAND);
  assign isLow = cellVoltage < terminateVoltage;

  // Saturating run lengths, restarted by any excursion
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inBandCnt_r <= 16'h0000;
      lowCnt_r <= 16'h0000;
    end else begin
      inBandCnt_r <= !inBand ? 16'h0000 :
                     inBandCnt_r + {15'h0000, inBandCnt_r != 16'hffff};
      lowCnt_r <= !isLow ? 16'h0000 :
                  lowCnt_r + {15'h0000, lowCnt_r != 16'hffff};
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_dsg_clear: assert property ((clkEn && !averagedCurrent[15]) [*3]
    |-> !dischargeFlag) else $error("discharge flag without discharge");
  chk_flag_excl: assert property (!(chargeFlag && dischargeFlag))
    else $error("charge and discharge flags together");
  chk_rest_time: assert property ($rose(restFlag)
    |-> inBandCnt_r >= CLK_HZ) else $error("rest entered too early");
  chk_ocv_pulse: assert property (ocvCapture |=> !ocvCapture)
    else $error("capture pulse longer than one cycle");
  chk_ocv_rest: assert property (ocvCapture |-> restFlag)
    else $error("capture outside rest");
  chk_scale_ocv: assert property (scaleReset |-> ocvCapture)
    else $error("scale reset without capture");
  chk_zero_time: assert property ($rose(forceZeroCapacity)
    |-> lowCnt_r >= CLK_HZ) else $error("zero forced too early");
  chk_smooth_rest: assert property (smoothActive |-> restFlag)
    else $error("smoothing outside rest");
  chk_wait_answer: assert property ((avsRead || avsWrite) && avsWaitRequest
    |-> ##[1:3] !avsWaitRequest) else $error("bus answer late");
  chk_wait_pulse: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low too long");
  chk_rdata_upper: assert property (!avsWaitRequest
    |-> avsReadData[31:16] == 16'h0000) else $error("upper read data set");

  // Main scenarios reached
  cov_rest: cover property ($rose(restFlag));
  cov_ocv: cover property (ocvCapture && scaleReset);
  cov_zero: cover property ($rose(forceZeroCapacity));
  cov_irq: cover property ($rose(interruptOutputPin));
endmodule

bind brsd_rest_detector brsd_rest_checker #(.CLK_HZ(CLK_HZ))
  brsd_rest_checker_i (.*);

// file: bench/brsd_cell_model.sv
`timescale 1ns/1ps
// ==========================================
// Cell measurement path: registered readings
module brsd_cell_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Wanted readings
  input wire logic signed [15:0] setCurrent,
  input wire logic [15:0] setVoltage,
  input wire logic [15:0] setTerm,
  input wire logic signed [15:0] setTemp,
  input wire logic [15:0] setSlope,
  // Readings to the detector
  output logic signed [15:0] averagedCurrent,
  output logic [15:0] cellVoltage,
  output logic [15:0] terminateVoltage,
  output logic signed [15:0] cellTemp,
  output logic [15:0] voltageSlope
);
  // One conversion cycle of delay, zero while in reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      averagedCurrent <= 16'sh0000;
      cellVoltage <= 16'h0000;
      terminateVoltage <= 16'h0000;
      cellTemp <= 16'sh0000;
      voltageSlope <= 16'h0000;
    end else begin
      averagedCurrent <= setCurrent;
      cellVoltage <= setVoltage;
      terminateVoltage <= setTerm;
      cellTemp <= setTemp;
      voltageSlope <= setSlope;
    end
  end
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
`include "brsd_params.svh"
// ==========================================
// Register-driven bench for the rest detector
module testbench;
  logic core_clk, sys_rst, clkEn, avsRead, avsWrite, avsWaitRequest;
  logic [7:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  logic [3:0] avsByteEnable;
  logic signed [15:0] averagedCurrent, cellTemp, setCurrent, setTemp;
  logic [15:0] cellVoltage, terminateVoltage, voltageSlope, setVoltage;
  logic [15:0] setTerm, setSlope, ocvValue, peakCurrent, v;
  logic dischargeFlag, chargeFlag, restFlag, ocvCapture, scaleReset;
  logic forceZeroCapacity, smoothActive, predictEnable, interruptOutputPin;
  int failures = 0;
  int num_checks = 0;
  localparam logic [7:0] IDX [13] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08,
    8'h6a, 8'h6c, 8'h6d, 8'h6f, 8'h70, 8'h72, 8'h74, 8'h76};
  localparam logic [15:0] RST [13] = '{16'h003c, 16'h004b, 16'h0028,
    16'h003c, 16'h003c, 16'h0028, 16'h000f, 16'h2134, 16'h000a, 16'h01f4,
    16'h03e8, 16'h07d0, 16'h0002};

  // Design and measurement path
  brsd_rest_detector #(.CLK_HZ(10)) brsd_rest_detector_i (.*);
  brsd_cell_model brsd_cell_model_i (.*);

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare two values
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    avsAddress <= a;
    avsWriteData <= {16'h0000, d};
    avsWrite <= w;
    avsRead <= !w;
    @(posedge core_clk);
    while (avsWaitRequest !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    q = avsReadData[15:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge core_clk);
    if (n >= 20) begin
      $display("mismatch at %0t: bus hang", $time);
      failures++;
      conclude();
    end
  endtask

  // Result flag picked by number
  function automatic logic sig(input int s);
    case (s)
      0: return dischargeFlag;
      1: return chargeFlag;
      2: return restFlag;
      3: return ocvCapture;
      4: return forceZeroCapacity;
      5: return predictEnable;
      default: return interruptOutputPin;
    endcase
  endfunction

  // Flag must reach a level between lo and hi cycles from now
  task automatic track(input int s, input logic lv, input int lo,
                       input int hi);
    int n;
    n = 0;
    while (sig(s) !== lv && n <= hi) begin
      @(posedge core_clk);
      n++;
    end
    num_checks++;
    if (n < lo || n > hi) begin
      $display("mismatch at %0t: flag %0d after %0d cycles", $time, s, n);
      failures++;
    end
    if (n > hi) begin
      conclude();
    end
  endtask

  // Wait for the peak figure to settle
  task automatic peakIs(input logic [15:0] e);
    int n;
    n = 0;
    while (peakCurrent !== e && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk(peakCurrent, e);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    $display("mismatch at %0t: run too long", $time);
    failures++;
    conclude();
  end

  // Main sequence
  initial begin
    {sys_rst, clkEn, avsRead, avsWrite, avsAddress} = {3'b110, 9'h000};
    {avsWriteData, avsByteEnable} = {32'h0000_0000, 4'h3};
    {setCurrent, setTemp, setSlope} = {16'sh0000, 16'sh0014, 16'h0002};
    {setVoltage, setTerm} = {16'h0ef6, 16'h0bb8};
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 13; i++) begin
      bus(1'b0, IDX[i], 16'h0000, v);
      chk(v, RST[i]);
    end
    bus(1'b1, 8'h10, 16'h1234, v);
    bus(1'b0, 8'h10, 16'h0000, v);
    chk(v, 16'h0000);
    // Peak figure and its interrupt
    peakIs(16'h2134);
    bus(1'b1, `BRSD_IDX_IRQ_MASK, 16'h0000, v);
    bus(1'b1, `BRSD_IDX_IRQ_STAT, 16'h0001, v);
    bus(1'b1, `BRSD_IDX_PULSE_DUR, 16'h0014, v);
    peakIs(16'h4268);
    bus(1'b0, `BRSD_IDX_IRQ_STAT, 16'h0000, v);
    chk({15'h0000, v[0]}, 16'h0001);
    chk({15'h0000, interruptOutputPin}, 16'h0000);
    bus(1'b1, `BRSD_IDX_IRQ_MASK, 16'h0001, v);
    track(6, 1'b1, 0, 5);
    bus(1'b1, `BRSD_IDX_IRQ_STAT, 16'h0001, v);
    track(6, 1'b0, 0, 5);
    bus(1'b1, `BRSD_IDX_PULSE_CUR, 16'h21fc, v);
    peakIs(16'h43f8);
    bus(1'b0, `BRSD_IDX_IRQ_STAT, 16'h0000, v);
    chk({15'h0000, v[0]}, 16'h0000);
    // Writes ignored while frozen
    clkEn <= 1'b0;
    bus(1'b1, `BRSD_IDX_DSG_DET, 16'h0099, v);
    clkEn <= 1'b1;
    bus(1'b0, `BRSD_IDX_DSG_DET, 16'h0000, v);
    chk(v, 16'h003c);
    // Short timers; rest band stays below both detection levels
    bus(1'b1, `BRSD_IDX_DSG_REST, 16'h0005, v);
    bus(1'b1, `BRSD_IDX_CHG_REST, 16'h0002, v);
    bus(1'b1, `BRSD_IDX_PREDICT, 16'h0003, v);
    // Discharge detection at its boundary
    setCurrent <= 16'shffc3;
    track(0, 1'b1, 0, 5);
    track(5, 1'b1, 15, 45);
    setCurrent <= 16'shffc4;
    track(0, 1'b0, 0, 5);
    // Rest from discharge, restarted by an excursion
    setCurrent <= 16'shff9c;
    repeat (3) @(posedge core_clk);
    setCurrent <= 16'sh0000;
    repeat (35) @(posedge core_clk);
    chk({15'h0000, restFlag}, 16'h0000);
    setCurrent <= 16'shffce;
    repeat (3) @(posedge core_clk);
    setCurrent <= 16'sh000a;
    track(2, 1'b1, 35, 70);
    // Charge, then rest from charge
    setCurrent <= 16'sh0064;
    track(1, 1'b1, 0, 5);
    chk({15'h0000, dischargeFlag}, 16'h0000);
    track(2, 1'b0, 0, 20);
    setCurrent <= 16'sh0000;
    track(1, 1'b0, 0, 5);
    track(2, 1'b1, 10, 35);
    chk({15'h0000, smoothActive}, 16'h0001);
    // Settled voltage captured after the settle period
    track(3, 1'b1, 17900, 18300);
    chk({15'h0000, scaleReset}, 16'h0001);
    chk(ocvValue, 16'h0ef6);
    chk({15'h0000, smoothActive}, 16'h0000);
    bus(1'b0, `BRSD_IDX_STATUS, 16'h0000, v);
    chk({15'h0000, v[4]}, 16'h0000);
    // Terminate dip, interrupted once
    setVoltage <= 16'h0b54;
    repeat (8) @(posedge core_clk);
    setVoltage <= 16'h0c1c;
    repeat (3) @(posedge core_clk);
    setVoltage <= 16'h0b54;
    track(4, 1'b1, 11, 35);
    conclude();
  end
endmodule
